/* File: rtl/mgif_pkg.sv */
// Shared constants and types for the three-phase gate command controller.
// Assumes a single 10 MHz clock domain; all pin timings are counted in its cycles.
package mgif_pkg;

	localparam int CLK_MHZ         = 10;
	localparam int NUM_PHASES      = 3;
	localparam int DEAD_TIME_NS    = 1500;
	localparam int MIN_PULSE_NS    = 500;
	localparam int SD_PULSE_NS     = 6000;
	localparam int MAX_CARRIER_KHZ = 20;

	// Least times round up to whole cycles.
	localparam logic [7:0]  DEAD_CYC       = 8'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  MIN_PULSE_CYC  = 8'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  SD_PULSE_CYC   = 8'((SD_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [15:0] MIN_PERIOD_CYC =
		16'((CLK_MHZ * 1000 + MAX_CARRIER_KHZ - 1) / MAX_CARRIER_KHZ);

	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PERIOD_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] DUTY_OFS [NUM_PHASES] = '{8'h08, 8'h0c, 8'h10};

	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_SD_HS_BIT = 1;
	localparam int CTRL_SD_LS_BIT = 2;
	localparam int ST_FAULT_BIT   = 0;
	localparam int ST_SD_HS_BIT   = 1;
	localparam int ST_SD_LS_BIT   = 2;
	localparam int ST_OCL_BIT     = 3;
	localparam int ST_RUN_BIT     = 4;

	localparam logic [2:0]  CTRL_RST   = 3'h0;
	localparam logic [15:0] PERIOD_RST = 16'h03e8;
	localparam logic [15:0] DUTY_RST   = 16'h0000;
	localparam logic [7:0]  TM_MAX     = 8'hff;

	typedef enum logic [1:0] {
		LEG_DEAD = 2'b00,
		LEG_HIGH = 2'b01,
		LEG_LOW  = 2'b10,
		LEG_IDLE = 2'b11
	} mgif_leg_state_t;

	typedef struct packed {
		mgif_leg_state_t st;
		logic [7:0]      tm;
	} mgif_leg_t;

	typedef struct packed {
		logic [NUM_PHASES-1:0] high_side_command;
		logic [NUM_PHASES-1:0] low_side_command;
	} mgif_gate_t;

	typedef struct packed {
		logic high_side_shutdown_fault;
		logic low_side_shutdown_fault;
	} mgif_sd_t;

endpackage

/* File: rtl/mgif_host_ctrl.sv */
// Controller that drives the inverter's six gate command inputs with dead time.
// Assumes APB3 software access, pulled-up shutdown/fault pins and a pulled-up limit flag.
//
// Notes on behaviour
// [R1] Each phase has active-high high-side and low-side command lines.
// [R2] Device reads undriven commands low; ours start low from reset.
// [R3] At least 1.5 us both off before the complementary switch turns on.
// [R4] Every high and low command pulse lasts at least 0.5 us; ours end at once when a fault or disable stops the leg.
// [R5] Carrier frequency never exceeds 20 kHz.
// [R6] Command lines are always actively driven, never high impedance.
// [R7] Device pulls the current-limit flag low while limiting.
// [R8] The flag may be wired to either shutdown pin; we only observe it.
// [R9] Device turns low sides off and pulls low-side shutdown low on overcurrent.
// [R10] Device discharges the hold-timer pin for about 5 us on trigger.
// [R11] Device releases protection when the hold-timer pin reaches 2.46 V.
// [R12] Hold time is about 1.35 RC at 3.3 V, 0.65 RC at 5 V.
// [R13] Missing resistor never releases, shorted never triggers, missing capacitor shortens.
// [R14] Each shutdown pin is both fault output and shutdown input.
// [R15] Device ignores low pulses shorter than about 3.3 us on shutdown pins.
// [R16] Shutdown pins are only pulled low; wired-AND with external pull-up.
// [R17] Low high-side pin stops high sides; low low-side pin stops low sides.
// [R18] Device faults drive the matching shutdown pin low.
// [R19] High sides restart only on a fresh rising command edge.
// [R20] Protection trips at 1.0 V held for 2.0 us blanking.
// [R21] Microsecond timings are counted in cycles of the model clock.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module mgif_host_ctrl
	import mgif_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  mgif_gate_t  gate_command,
	input  wire mgif_sd_t    shutdown_fault_pin_in,
	output var  mgif_sd_t    shutdown_fault_pin_out,
	output var  mgif_sd_t    shutdown_fault_pin_oe,
	input  wire logic        current_limit_flag
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers.

	mgif_sd_t sd_s1_r;
	mgif_sd_t sd_s2_r;
	logic     ocl_s1_r;
	logic     ocl_s2_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sd_s1_r  <= '1;
			sd_s2_r  <= '1;
			ocl_s1_r <= 1'b1;
			ocl_s2_r <= 1'b1;
		end else begin
			sd_s1_r  <= shutdown_fault_pin_in; // R14
			sd_s2_r  <= sd_s1_r;
			ocl_s1_r <= current_limit_flag; // R7
			ocl_s2_r <= ocl_s1_r;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Register file.

	logic [2:0]  ctrl_r,   ctrl_nxt;
	logic [15:0] period_r, period_nxt;
	logic [15:0] duty_r   [NUM_PHASES];
	logic [15:0] duty_nxt [NUM_PHASES];
	logic        fault_r,  fault_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        run;
	logic [15:0] eff_period;
	logic        setup;
	logic        wr;
	logic        mapped;
	logic [31:0] rd_mux;
	logic        fault_set;

	assign setup = psel & ~penable;
	assign wr    = psel & penable & pwrite;
	assign run   = ctrl_r[CTRL_EN_BIT] & ~fault_r;

	// Either pin low means the device or the board wants the bridge quiet; a shutdown that
	// software itself requested latches the flag as well, which keeps the logic simple.
	assign fault_set = ~sd_s2_r.high_side_shutdown_fault | ~sd_s2_r.low_side_shutdown_fault; // R18

	always_comb begin
		ctrl_nxt    = ctrl_r;
		period_nxt  = period_r;
		duty_nxt    = duty_r;
		mapped      = 1'b0;
		rd_mux      = 32'h0000_0000;
		case (paddr)
			CTRL_OFS: begin
				mapped = 1'b1;
				rd_mux = {29'h0, ctrl_r};
			end
			PERIOD_OFS: begin
				mapped = 1'b1;
				rd_mux = {16'h0000, period_r};
			end
			STATUS_OFS: begin
				mapped = 1'b1;
				rd_mux[ST_FAULT_BIT] = fault_r;
				rd_mux[ST_SD_HS_BIT] = sd_s2_r.high_side_shutdown_fault;
				rd_mux[ST_SD_LS_BIT] = sd_s2_r.low_side_shutdown_fault;
				rd_mux[ST_OCL_BIT]   = ocl_s2_r; // R8
				rd_mux[ST_RUN_BIT]   = run;
			end
			default: begin
			end
		endcase
		for (int i = 0; i < NUM_PHASES; i++) begin
			if (paddr == DUTY_OFS[i]) begin
				mapped = 1'b1;
				rd_mux = {16'h0000, duty_r[i]};
				if (wr) begin
					duty_nxt[i] = pwdata[15:0];
				end
			end
		end
		if (wr && paddr == CTRL_OFS) begin
			ctrl_nxt = pwdata[2:0];
		end
		if (wr && paddr == PERIOD_OFS) begin
			period_nxt = pwdata[15:0];
		end
		// Set wins over the write-one-to-clear.
		fault_nxt = fault_set | (fault_r &
			~(wr && paddr == STATUS_OFS && pwdata[ST_FAULT_BIT]));
		prdata_nxt  = (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		pslverr_nxt = setup & ~mapped;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= CTRL_RST;
			period_r  <= PERIOD_RST;
			duty_r    <= '{default: DUTY_RST};
			fault_r   <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			period_r  <= period_nxt;
			duty_r    <= duty_nxt;
			fault_r   <= fault_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign pready  = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// Carrier counter and dead-time legs.

	logic [15:0]     pwm_cnt_r, pwm_cnt_nxt;
	mgif_leg_t       leg_r   [NUM_PHASES];
	mgif_leg_t       leg_nxt [NUM_PHASES];
	mgif_gate_t      gate_r,  gate_nxt;

	// Short periods are stretched so the carrier can never exceed its limit.
	assign eff_period = (period_r < MIN_PERIOD_CYC) ? MIN_PERIOD_CYC : period_r; // R5

	function automatic mgif_leg_t leg_step(mgif_leg_t cur, logic want_high, logic go);
		mgif_leg_t nx;
		nx    = cur;
		nx.tm = (cur.tm == TM_MAX) ? cur.tm : cur.tm + 8'h01;
		if (!go) begin
			nx.st = LEG_IDLE; // R17
		end else begin
			case (cur.st)
				LEG_IDLE: nx.st = LEG_DEAD; // R19
				LEG_DEAD: if (cur.tm >= DEAD_CYC - 8'h01) begin // R3
					nx.st = want_high ? LEG_HIGH : LEG_LOW;
				end
				LEG_HIGH: if (!want_high && cur.tm >= MIN_PULSE_CYC - 8'h01) begin // R4
					nx.st = LEG_DEAD;
				end
				LEG_LOW: if (want_high && cur.tm >= MIN_PULSE_CYC - 8'h01) begin // R4
					nx.st = LEG_DEAD;
				end
				default: nx.st = LEG_IDLE;
			endcase
		end
		if (nx.st != cur.st) begin
			nx.tm = 8'h00;
		end
		return nx;
	endfunction

	for (genvar i = 0; i < NUM_PHASES; i++) begin : g_leg
		assign leg_nxt[i] = leg_step(leg_r[i], pwm_cnt_r < duty_r[i], run);
	end

	always_comb begin
		pwm_cnt_nxt = (!run || pwm_cnt_r >= eff_period - 16'h0001) ? 16'h0000
			: pwm_cnt_r + 16'h0001;
		for (int i = 0; i < NUM_PHASES; i++) begin
			gate_nxt.high_side_command[i] = (leg_nxt[i].st == LEG_HIGH); // R1
			gate_nxt.low_side_command[i]  = (leg_nxt[i].st == LEG_LOW); // R1
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_cnt_r <= 16'h0000;
			leg_r     <= '{default: '{st: LEG_IDLE, tm: 8'h00}};
			gate_r    <= '0; // R2
		end else begin
			pwm_cnt_r <= pwm_cnt_nxt;
			leg_r     <= leg_nxt;
			gate_r    <= gate_nxt;
		end
	end

	// Both levels are always driven from a flop; there is no enable on these lines.
	assign gate_command = gate_r; // R6

////////////////////////////////////////////////////////////////////////////////
// Shutdown pin drive: low only, held long enough to pass the device's filter.

	logic [1:0] sd_oe_r,   sd_oe_nxt;
	logic [7:0] sd_hold_r [2];
	logic [7:0] sd_hold_nxt [2];
	logic [1:0] sd_req;

	assign sd_req = {ctrl_r[CTRL_SD_HS_BIT], ctrl_r[CTRL_SD_LS_BIT]};

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			sd_oe_nxt[p]   = sd_oe_r[p];
			sd_hold_nxt[p] = sd_hold_r[p];
			if (sd_req[p]) begin
				sd_oe_nxt[p]   = 1'b1;
				sd_hold_nxt[p] = 8'h00;
			end else if (sd_oe_r[p] && sd_hold_r[p] < SD_PULSE_CYC - 8'h01) begin // R15
				sd_hold_nxt[p] = sd_hold_r[p] + 8'h01;
			end else begin
				sd_oe_nxt[p] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sd_oe_r   <= 2'h0;
			sd_hold_r <= '{default: 8'h00};
		end else begin
			sd_oe_r   <= sd_oe_nxt;
			sd_hold_r <= sd_hold_nxt;
		end
	end

	assign shutdown_fault_pin_oe  = sd_oe_r;
	assign shutdown_fault_pin_out = '0; // R16

////////////////////////////////////////////////////////////////////////////////
// Checks.

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [7:0] hs_on_cnt_r  [NUM_PHASES];
	logic [7:0] hs_off_cnt_r [NUM_PHASES];
	logic [7:0] ls_off_cnt_r [NUM_PHASES];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_on_cnt_r  <= '{default: 8'h00};
			hs_off_cnt_r <= '{default: 8'h00};
			ls_off_cnt_r <= '{default: 8'h00};
		end else begin
			for (int i = 0; i < NUM_PHASES; i++) begin
				hs_on_cnt_r[i]  <= (!gate_r.high_side_command[i]) ? 8'h00
					: (hs_on_cnt_r[i] == TM_MAX) ? TM_MAX : hs_on_cnt_r[i] + 8'h01;
				hs_off_cnt_r[i] <= gate_r.high_side_command[i] ? 8'h00
					: (hs_off_cnt_r[i] == TM_MAX) ? TM_MAX : hs_off_cnt_r[i] + 8'h01;
				ls_off_cnt_r[i] <= gate_r.low_side_command[i] ? 8'h00
					: (ls_off_cnt_r[i] == TM_MAX) ? TM_MAX : ls_off_cnt_r[i] + 8'h01;
			end
		end
	end

	for (genvar i = 0; i < NUM_PHASES; i++) begin : g_chk
		property p_dead_hs;
			$rose(gate_command.high_side_command[i]) |-> ls_off_cnt_r[i] >= DEAD_CYC;
		endproperty
		a_dead_hs: assert property (p_dead_hs) else $error("high side on too soon"); // R3

		property p_dead_ls;
			$rose(gate_command.low_side_command[i]) |-> hs_off_cnt_r[i] >= DEAD_CYC;
		endproperty
		a_dead_ls: assert property (p_dead_ls) else $error("low side on too soon"); // R3

		property p_min_on;
			$fell(gate_command.high_side_command[i]) && $past(run)
				|-> $past(hs_on_cnt_r[i]) >= MIN_PULSE_CYC - 8'h01;
		endproperty
		a_min_on: assert property (p_min_on) else $error("high pulse too short"); // R4

		property p_no_overlap;
			!(gate_command.high_side_command[i] && gate_command.low_side_command[i]);
		endproperty
		a_no_overlap: assert property (p_no_overlap) else $error("both switches on"); // R3
	end

	property p_carrier;
		(run && pwm_cnt_r == eff_period - 16'h0001)
			|-> (eff_period >= MIN_PERIOD_CYC) ##1 (pwm_cnt_r == 16'h0000);
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier period too short"); // R5

	property p_fault_stop;
		!sd_s2_r.low_side_shutdown_fault |=> fault_r ##1 (gate_command == '0);
	endproperty
	a_fault_stop: assert property (p_fault_stop) else $error("commands not stopped"); // R17

	property p_shutdown_drive;
		ctrl_r[CTRL_SD_LS_BIT] |=> shutdown_fault_pin_oe.low_side_shutdown_fault
			&& !shutdown_fault_pin_out.low_side_shutdown_fault;
	endproperty
	a_shutdown_drive: assert property (p_shutdown_drive) else $error("pin not pulled"); // R16

	c_leg_high: cover property ($rose(gate_command.high_side_command[0]));
	c_leg_low: cover property ($rose(gate_command.low_side_command[0]));
	c_fault: cover property ($rose(fault_r));
	c_slverr: cover property (psel && penable && pslverr);

endmodule

`default_nettype wire

/* File: dv/mgif_dev_model.sv */
// Behavioural model of the inverter driver seen from its logic pins.
// Assumes the bench drives the fault sources and counts in pclk cycles.
`timescale 1ns/1ns
`default_nettype none
module mgif_dev_model
	import mgif_pkg::*;
#(
	parameter int DIS_CYC   = 50,
	parameter int HOLD_CYC  = 200,
	parameter int BLANK_CYC = 20,
	parameter int FILT_CYC  = 33
)(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire mgif_gate_t gate_command,
	input  wire mgif_sd_t   pull_oe,
	input  wire logic       ocp_trip,
	input  wire logic       limit_on,
	input  wire logic       uv_high,
	input  wire logic       uv_low,
	output var  mgif_sd_t   pin_level,
	output var  logic       flag_level,
	output var  int         n_viol
);
	////////////////////////////////////////////////////////////////
	int         hold_cnt;
	int         blank_cnt;
	int         pull_cnt [2];
	logic [7:0] off_cnt [NUM_PHASES];
	mgif_gate_t gate_q;
	logic       hs;
	logic       ls;
	logic       rise;
	// The limit flag is wired onto the high-side pin here.
	assign flag_level = !limit_on;
	assign pin_level.high_side_shutdown_fault =
		!(pull_oe.high_side_shutdown_fault | uv_high | limit_on);
	assign pin_level.low_side_shutdown_fault =
		!(pull_oe.low_side_shutdown_fault | uv_low | (hold_cnt != 0));
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= 0;
			blank_cnt <= 0;
			pull_cnt <= '{default: 0};
			n_viol <= 0;
			gate_q <= '0;
			off_cnt <= '{default: '0};
		end else begin
			// Protection trips only once the sense level has stood for the blanking time.
			blank_cnt <= ocp_trip ? blank_cnt + 1 : 0;
			// A zero hold stands for a shorted timing resistor, which never trips.
			// Discharge time plus recharge to threshold, in model cycles.
			if (ocp_trip && blank_cnt >= BLANK_CYC - 1 && hold_cnt == 0 && HOLD_CYC != 0) begin
				hold_cnt <= DIS_CYC + HOLD_CYC;
			end else if (hold_cnt != 0) begin
				hold_cnt <= hold_cnt - 1;
			end
			gate_q <= gate_command;
			// A pull shorter than the pin filter would go unseen by the device.
			for (int p = 0; p < 2; p++) begin
				if (pull_oe[p]) begin
					pull_cnt[p] <= pull_cnt[p] + 1;
				end else begin
					if (pull_cnt[p] != 0 && pull_cnt[p] < FILT_CYC) begin
						n_viol <= n_viol + 1;
					end
					pull_cnt[p] <= 0;
				end
			end
			for (int i = 0; i < NUM_PHASES; i++) begin
				// Only a driven high counts as on; anything else reads low.
				hs = gate_command.high_side_command[i] === 1'b1;
				ls = gate_command.low_side_command[i] === 1'b1;
				rise = (hs && gate_q.high_side_command[i] !== 1'b1) ||
					(ls && gate_q.low_side_command[i] !== 1'b1);
				if ((hs && ls) || (rise && off_cnt[i] < DEAD_CYC)) begin
					n_viol <= n_viol + 1;
				end
				if (hs || ls) begin
					off_cnt[i] <= '0;
				end else if (off_cnt[i] != 8'hff) begin
					off_cnt[i] <= off_cnt[i] + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/motor_gate_input_fault_logic_test.sv */
// Self-checking bench for the gate command controller over APB.
// Assumes the device model stands on the gate, shutdown and flag pins.
`timescale 1ns/1ns
`default_nettype none
module motor_gate_input_fault_logic_test import mgif_pkg::*;;
	////////////////////////////////////////////////////////////////
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic        pready, pslverr, e, flag_level;
	logic        ocp_trip = 0, limit_on = 0, uv_high = 0, uv_low = 0;
	logic [31:0] duties [2] = '{32'h00000010, 32'h000000fa};
	logic [31:0] st_exp [4] = '{32'h0000000b, 32'h00000005, 32'h0000000d, 32'h0000000b};
	mgif_gate_t  gate_command;
	mgif_sd_t    sd_oe, sd_level, sd_out;
	int          n_errors = 0, num_checks = 0, n_viol, len, per;
	always #50 pclk = ~pclk;
	mgif_host_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gate_command(gate_command), .shutdown_fault_pin_in(sd_level),
		.shutdown_fault_pin_out(sd_out), .shutdown_fault_pin_oe(sd_oe),
		.current_limit_flag(flag_level));
	mgif_dev_model dev_u (.pclk(pclk), .presetn(presetn), .gate_command(gate_command),
		.pull_oe(sd_oe), .ocp_trip(ocp_trip), .limit_on(limit_on), .uv_high(uv_high),
		.uv_low(uv_low), .pin_level(sd_level), .flag_level(flag_level), .n_viol(n_viol));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(what, exp, q);
	endtask
	// Waits out any hold, clears the latched fault and expects a running leg.
	task automatic recover(input string what);
		cyc(300);
		apb(1'b1, STATUS_OFS, 32'h1);
		rd(what, STATUS_OFS, 32'h1e);
	endtask
	// Rise-to-rise period and high time of phase 0's high-side command.
	task automatic measure();
		len = 0;
		while (gate_command.high_side_command[0] !== 1'b1) @(posedge pclk);
		while (gate_command.high_side_command[0] === 1'b1) begin
			@(posedge pclk);
			len++;
		end
		per = len;
		while (gate_command.high_side_command[0] !== 1'b1) begin
			@(posedge pclk);
			per++;
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#3000000;
		n_errors++;
		final_report();
	end
	initial begin
		cyc(10);
		presetn <= 1'b1;
		chk("gate at reset", 32'h0, 32'(gate_command));
		rd("ctrl reset", CTRL_OFS, 32'h0);
		rd("period reset", PERIOD_OFS, 32'h3e8);
		rd("duty reset", DUTY_OFS[0], 32'h0);
		rd("status idle", STATUS_OFS, 32'h0e);
		rd("unmapped read", 8'h18, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
		$display("Test registers done");
		// A period below the carrier floor must be raised to it.
		// The first duty wants high barely longer than the dead time, so the pulse floor must stretch it.
		apb(1'b1, PERIOD_OFS, 32'h64);
		apb(1'b1, CTRL_OFS, 32'h1);
		foreach (duties[k]) begin
			apb(1'b1, DUTY_OFS[0], duties[k]);
			measure();
			measure();
			chk("carrier period", 32'(MIN_PERIOD_CYC), 32'(per));
			chk("pulse floor", 32'h1, 32'(len >= int'(MIN_PULSE_CYC)));
		end
		$display("Test carrier done");
		apb(1'b1, CTRL_OFS, 32'h5);
		cyc(10);
		chk("pin pulled", 32'h0, 32'(sd_level.low_side_shutdown_fault));
		chk("pin enable", 32'h1, 32'(sd_oe));
		chk("pin drive level", 32'h0, 32'(sd_out));
		chk("gate off", 32'h0, 32'(gate_command));
		rd("status request", STATUS_OFS, 32'h0b);
		apb(1'b1, CTRL_OFS, 32'h1);
		recover("status released");
		$display("Test shutdown request done");
		for (int k = 0; k < 4; k++) begin
			{ocp_trip, limit_on, uv_high, uv_low} <= 4'h8 >> k;
			cyc(25);
			ocp_trip <= 1'b0;
			cyc(20);
			chk("gate on fault", 32'h0, 32'(gate_command));
			chk("limit flag", 32'(k != 1), 32'(flag_level));
			rd("status fault", STATUS_OFS, st_exp[k]);
			{ocp_trip, limit_on, uv_high, uv_low} <= 4'h0;
			recover("status recovered");
		end
		$display("Test faults done");
		measure();
		chk("dead time", 32'h0, 32'(n_viol));
		apb(1'b1, CTRL_OFS, 32'h0);
		cyc(5);
		chk("gate disabled", 32'h0, 32'(gate_command));
		$display("Test disable done");
		final_report();
	end
endmodule
`default_nettype wire
